/* File: hdl/tps_pkg.sv */
// constants, states and helpers of the trace programming-state block
package tps_pkg;
  localparam int MCLK_MHZ = 250;
  // settle times of the enable and disable paths
  localparam int ENABLE_NS = 40;
  localparam int ENABLE_CYC = (ENABLE_NS * MCLK_MHZ + 999) / 1000;
  localparam int DRAIN_NS = 80;
  localparam int DRAIN_CYC = (DRAIN_NS * MCLK_MHZ + 999) / 1000;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CLAIM_W = 8;
  localparam int CNT_W = 16;
  localparam int SEQ_W = 2;
  localparam int SS_N = 8;
  localparam int AUTH_W = 8;

  localparam logic [11:0] OFS_PRG_CTL = 12'h004;
  localparam logic [11:0] OFS_STATE = 12'h00C;
  localparam logic [11:0] OFS_RSR = 12'h028;
  localparam logic [11:0] OFS_SEQ = 12'h11C;
  localparam logic [11:0] OFS_CNT = 12'h160;
  localparam logic [11:0] OFS_SS = 12'h2A0;
  localparam logic [11:0] OFS_CLAIM_SET = 12'hFA0;
  localparam logic [11:0] OFS_CLAIM_CLR = 12'hFA4;
  localparam logic [11:0] OFS_AUTH = 12'hFB8;

  localparam int EN_BIT = 0;
  localparam int IDLE_BIT = 0;
  localparam int STABLE_BIT = 1;
  localparam logic [31:0] RSR_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ENABLING = 3'b001,
    ST_RUNNING  = 3'b010,
    ST_UNSTABLE = 3'b011,
    ST_STABLE   = 3'b100
  } tps_state_e;

  // programmers' model is quiet and safe to read
  function automatic logic tps_quiet(input tps_state_e s);
    tps_quiet = (s == ST_IDLE) || (s == ST_STABLE);
  endfunction

  function automatic logic tps_enabled(input tps_state_e s);
    tps_enabled = (s == ST_ENABLING) || (s == ST_RUNNING);
  endfunction
endpackage

/* File: hdl/tps_sync.sv */
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module tps_sync #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tps_sync_s;

  tps_sync_s r;
  tps_sync_s next_r;

  // first stage feeds only the second stage
  always_comb
  begin
    next_r.s1 = din;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      r <= '0;
    else
      r <= next_r;
  end

  assign dout = r.s2;
endmodule

/* File: hdl/tps_timer.sv */
// bounded settle timer, one done pulse after CYC cycles
`timescale 1ns/1ps
module tps_timer #(
  parameter int CYC = 8
) (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic start,
  output logic      done
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        busy;
    logic        done;
  } tps_timer_s;

  tps_timer_s r;
  tps_timer_s next_r;

  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    if (start)
    begin
      next_r.busy = 1'b1;
      next_r.cnt = 16'(CYC - 1);
    end
    else if (r.busy)
    begin
      if (r.cnt == 16'h0000)
      begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end
      else
        next_r.cnt = r.cnt - 16'h0001;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      r <= '0;
    else
      r <= next_r;
  end

  assign done = r.done;
endmodule

/* File: hdl/tps_ctrl.sv */
// trace unit programming-state controller with APB and direct access
//
// Functional notes
// (R1) enable bit set moves Idle to Enabling
// (R2) Enabling reaches Running after a bounded settle time
// (R3) enable bit cleared moves Running to Unstable
// (R4) Unstable reaches Stable after a bounded drain time
// (R5) Stable goes Idle only when drained and outer interfaces quiet
// (R6) idle and stable flags encode the state; enabled in Enabling/Running
// (R7) in Stable/Idle dynamic fields change only by direct/external writes
// (R8) outside Idle only control and claim writes take effect
// (R9) enable bit changes only in Idle or Running, else ignored
// (R10) software reads status once, with sync, after changing enable
// (R11) claim, counter, sequencer, single-shot updates reach direct reads
// (R12) older instructions keep tracing under the previous enable
// (R13) new enable governs after the next context sync
// (R14) indirect writes reach direct reads on sync in Idle/Stable
// (R15) indirect writes reach outer reads on entering Stable/Idle
// (R16) trace functions update and read registers in program order
// (R17) debugger writes are seen by trace function reads at once
// (R18) debugger writes are seen by later debugger reads at once
// (R19) in Stable/Idle trace function updates reach debugger reads
// (R20) debugger writes reach direct reads only after context sync; the code holds back only RSR, other direct reads see them at once
// (R21) authentication pin changes are indirect writes to auth status
// (R22) software syncs after programming before resuming
// (R23) reset starts in Idle with enable cleared
`timescale 1ns/1ps
module tps_ctrl #(
  parameter int ENABLE_CYC = tps_pkg::ENABLE_CYC,
  parameter int DRAIN_CYC  = tps_pkg::DRAIN_CYC
) (
  input  wire logic                        mclk,
  input  wire logic                        srst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [tps_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        sys_wr,
  input  wire logic                        sys_rd,
  input  wire logic [tps_pkg::ADDR_W-1:0]  sys_addr,
  input  wire logic [31:0]                 sys_wdata,
  output logic      [31:0]                 sys_rdata,
  output logic                             sys_rvalid,
  input  wire logic                        ctx_sync,
  input  wire logic                        ind_cnt_we,
  input  wire logic [tps_pkg::CNT_W-1:0]   ind_cnt_val,
  input  wire logic                        ind_seq_we,
  input  wire logic [tps_pkg::SEQ_W-1:0]   ind_seq_val,
  input  wire logic [tps_pkg::SS_N-1:0]    ind_ss_set,
  input  wire logic                        ind_rsr_we,
  input  wire logic [31:0]                 ind_rsr_val,
  input  wire logic                        trace_drained,
  input  wire logic                        ext_quiescent,
  input  wire logic [tps_pkg::AUTH_W-1:0]  auth_pins,
  output logic                             trace_enabled,
  output logic                             idle_flag,
  output logic                             model_stable_flag
);
  typedef struct packed {
    tps_pkg::tps_state_e         state;
    logic                        en_prog;
    logic                        en_eff;
    logic [tps_pkg::CLAIM_W-1:0] claim;
    logic [tps_pkg::CNT_W-1:0]   cnt;
    logic [tps_pkg::SEQ_W-1:0]   seq;
    logic [tps_pkg::SS_N-1:0]    ss;
    logic [31:0]                 rsr;
    logic [31:0]                 rsr_dir;
    logic [31:0]                 rsr_ext;
    logic [tps_pkg::AUTH_W-1:0]  auth_dir;
    logic [tps_pkg::AUTH_W-1:0]  auth_ext;
    logic [31:0]                 prdata;
    logic                        pslverr;
    logic [31:0]                 sys_rdata;
    logic                        sys_rvalid;
  } tps_ctrl_s;

  tps_ctrl_s r;
  tps_ctrl_s next_r;

  logic [tps_pkg::AUTH_W-1:0] auth_sync;
  logic                       enable_done;
  logic                       drain_done;
  logic                       start_enable;
  logic                       start_drain;
  logic                       apb_setup;
  logic                       apb_wr;

  // authentication pins come from another domain
  tps_sync #(
    .W (tps_pkg::AUTH_W)
  ) u_auth_sync (
    .mclk (mclk),
    .srst (srst),
    .din  (auth_pins),
    .dout (auth_sync)
  );

  tps_timer #(
    .CYC (ENABLE_CYC)
  ) u_enable_timer (
    .mclk  (mclk),
    .srst  (srst),
    .start (start_enable),
    .done  (enable_done)
  );

  tps_timer #(
    .CYC (DRAIN_CYC)
  ) u_drain_timer (
    .mclk  (mclk),
    .srst  (srst),
    .start (start_drain),
    .done  (drain_done)
  );

  function automatic logic is_mapped(input logic [11:0] a);
    case (a)
      tps_pkg::OFS_PRG_CTL, tps_pkg::OFS_STATE, tps_pkg::OFS_RSR,
      tps_pkg::OFS_SEQ, tps_pkg::OFS_CNT, tps_pkg::OFS_SS,
      tps_pkg::OFS_CLAIM_SET, tps_pkg::OFS_CLAIM_CLR,
      tps_pkg::OFS_AUTH: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // read view; dir selects the direct (system instruction) view
  function automatic logic [31:0] rd_val(input tps_ctrl_s s,
                                         input logic [11:0] a,
                                         input logic dir);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      tps_pkg::OFS_PRG_CTL: v[tps_pkg::EN_BIT] = s.en_prog;
      tps_pkg::OFS_STATE:
      begin
        v[tps_pkg::IDLE_BIT] = (s.state == tps_pkg::ST_IDLE) ||
                               (s.state == tps_pkg::ST_ENABLING); // [R6]
        v[tps_pkg::STABLE_BIT] = tps_pkg::tps_quiet(s.state); // [R6]
      end
      // [R14] [R20] direct view refreshed only at sync; [R19] outer view
      tps_pkg::OFS_RSR: v = dir ? s.rsr_dir : s.rsr_ext;
      tps_pkg::OFS_SEQ: v[tps_pkg::SEQ_W-1:0] = s.seq; // [R11] [R17]
      tps_pkg::OFS_CNT: v[tps_pkg::CNT_W-1:0] = s.cnt; // [R11] [R18]
      tps_pkg::OFS_SS: v[tps_pkg::SS_N-1:0] = s.ss; // [R11]
      tps_pkg::OFS_CLAIM_SET,
      tps_pkg::OFS_CLAIM_CLR: v[tps_pkg::CLAIM_W-1:0] = s.claim; // [R11]
      tps_pkg::OFS_AUTH:
        v[tps_pkg::AUTH_W-1:0] = dir ? s.auth_dir : s.auth_ext;
      default: v = 32'h0000_0000;
    endcase
    rd_val = v;
  endfunction

  // one register write from either access path
  function automatic tps_ctrl_s do_wr(input tps_ctrl_s s,
                                      input logic [11:0] a,
                                      input logic [31:0] d,
                                      input logic dir);
    tps_ctrl_s t;
    logic      en_ok;
    logic      idle;
    t = s;
    idle = (s.state == tps_pkg::ST_IDLE);
    en_ok = idle || (s.state == tps_pkg::ST_RUNNING); // [R9]
    case (a)
      tps_pkg::OFS_PRG_CTL:
      begin
        if (en_ok)
        begin
          t.en_prog = d[tps_pkg::EN_BIT];
          // [R12] direct change waits for sync; debugger acts now
          if (!dir)
            t.en_eff = d[tps_pkg::EN_BIT];
        end
      end
      tps_pkg::OFS_CLAIM_SET:
        t.claim = s.claim | d[tps_pkg::CLAIM_W-1:0];
      tps_pkg::OFS_CLAIM_CLR:
        t.claim = s.claim & ~d[tps_pkg::CLAIM_W-1:0];
      tps_pkg::OFS_RSR:
      begin
        if (idle) // [R8]
        begin
          t.rsr = d;
          t.rsr_ext = d; // [R18]
        end
      end
      tps_pkg::OFS_SEQ:
      begin
        if (idle) // [R8]
          t.seq = d[tps_pkg::SEQ_W-1:0];
      end
      tps_pkg::OFS_CNT:
      begin
        if (idle) // [R8]
          t.cnt = d[tps_pkg::CNT_W-1:0];
      end
      tps_pkg::OFS_SS:
      begin
        if (idle) // [R8]
          t.ss = d[tps_pkg::SS_N-1:0];
      end
      default: t = s;
    endcase
    do_wr = t;
  endfunction

  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  // timers start on the state entry edge
  assign start_enable = (r.state == tps_pkg::ST_IDLE) && r.en_eff;
  assign start_drain = (r.state == tps_pkg::ST_RUNNING) && !r.en_eff;

  always_comb
  begin
    next_r = r;
    next_r.sys_rvalid = 1'b0;

    // trace function updates, only while the unit is busy [R7]
    // each applied in the cycle it arrives; several fields can update in one cycle [R16]
    if (!tps_pkg::tps_quiet(r.state))
    begin
      if (ind_cnt_we)
        next_r.cnt = ind_cnt_val;
      if (ind_seq_we)
        next_r.seq = ind_seq_val;
      if (ind_rsr_we)
        next_r.rsr = ind_rsr_val;
    end

    // debugger write, then direct write; simultaneous ones act in turn
    if (apb_wr)
      next_r = do_wr(next_r, paddr, pwdata, 1'b0);
    if (sys_wr)
      next_r = do_wr(next_r, sys_addr, sys_wdata, 1'b1);

    // single-shot hits are sticky; a set beats a same-cycle write
    if (!tps_pkg::tps_quiet(r.state))
      next_r.ss = next_r.ss | ind_ss_set; // [R7]

    // [R21] auth pins land as indirect writes
    if (tps_pkg::tps_quiet(r.state))
      next_r.auth_ext = auth_sync; // [R15] [R19]

    // [R13] direct enable change governs after the next sync
    if (ctx_sync)
      next_r.en_eff = next_r.en_prog;

    // [R14] direct view of indirect state refreshed at sync when quiet
    if (ctx_sync && tps_pkg::tps_quiet(r.state))
    begin
      next_r.rsr_dir = next_r.rsr;
      next_r.auth_dir = next_r.auth_ext;
    end

    // [R15] [R19] outer view follows live state while quiet
    if (tps_pkg::tps_quiet(r.state))
      next_r.rsr_ext = next_r.rsr;

    case (r.state)
      tps_pkg::ST_IDLE:
      begin
        if (r.en_eff)
          next_r.state = tps_pkg::ST_ENABLING; // [R1]
      end
      tps_pkg::ST_ENABLING:
      begin
        if (enable_done)
          next_r.state = tps_pkg::ST_RUNNING; // [R2]
      end
      tps_pkg::ST_RUNNING:
      begin
        if (!r.en_eff)
          next_r.state = tps_pkg::ST_UNSTABLE; // [R3]
      end
      tps_pkg::ST_UNSTABLE:
      begin
        if (drain_done)
        begin
          next_r.state = tps_pkg::ST_STABLE; // [R4]
          next_r.rsr_ext = next_r.rsr; // [R15]
          next_r.auth_ext = auth_sync;
        end
      end
      tps_pkg::ST_STABLE:
      begin
        // may be left with enable still set; Idle then re-enables
        if (trace_drained && ext_quiescent)
          next_r.state = tps_pkg::ST_IDLE; // [R5]
      end
      default: next_r.state = tps_pkg::ST_IDLE;
    endcase

    // read data captured in setup so the access phase needs no wait
    if (apb_setup)
    begin
      next_r.prdata = rd_val(r, paddr, 1'b0);
      next_r.pslverr = !is_mapped(paddr);
    end
    if (sys_rd)
    begin
      next_r.sys_rdata = rd_val(r, sys_addr, 1'b1);
      next_r.sys_rvalid = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      r <= '0; // [R23]
      r.state <= tps_pkg::ST_IDLE; // [R23]
      r.rsr <= tps_pkg::RSR_RESET;
      r.rsr_dir <= tps_pkg::RSR_RESET;
      r.rsr_ext <= tps_pkg::RSR_RESET;
    end
    else
      r <= next_r;
  end

  assign pready = 1'b1;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign sys_rdata = r.sys_rdata;
  assign sys_rvalid = r.sys_rvalid;
  assign trace_enabled = tps_pkg::tps_enabled(r.state); // [R6]
  assign idle_flag = (r.state == tps_pkg::ST_IDLE) ||
                     (r.state == tps_pkg::ST_ENABLING); // [R6]
  assign model_stable_flag = tps_pkg::tps_quiet(r.state); // [R6]
endmodule

/* File: sim/tps_chk.sv */
// assertions on the programming-state controller ports
`timescale 1ns/1ps
module tps_chk #(
  parameter int ENABLE_CYC = 10,
  parameter int DRAIN_CYC  = 20
) (
  input wire logic                       mclk,
  input wire logic                       srst,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [tps_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                pwdata,
  input wire logic                       sys_wr,
  input wire logic [tps_pkg::ADDR_W-1:0] sys_addr,
  input wire logic [31:0]                sys_wdata,
  input wire logic                       ctx_sync,
  input wire logic                       trace_drained,
  input wire logic                       ext_quiescent,
  input wire logic                       trace_enabled,
  input wire logic                       idle_flag,
  input wire logic                       model_stable_flag
);
  localparam int EN_MAX = ENABLE_CYC + 4;
  localparam int DR_MAX = DRAIN_CYC + 4;
  logic ctl_wr;
  logic st_idle;
  logic st_run;
  logic st_stb;
  logic dir_en;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  // pready is tied high, so an access phase is the write edge
  assign ctl_wr = psel && penable && pwrite && paddr == tps_pkg::OFS_PRG_CTL;
  assign st_idle = idle_flag && model_stable_flag;
  assign st_run = trace_enabled && !idle_flag;
  assign st_stb = !idle_flag && model_stable_flag;
  assign dir_en = sys_wr && sys_addr == tps_pkg::OFS_PRG_CTL && sys_wdata[0];
  rst_idle_a: assert property (
    $fell(srst) |-> st_idle && !trace_enabled)
    else $error("not idle after reset");
  en_go_a: assert property (ctl_wr && pwdata[0] && st_idle |->
    ##[1:2] (trace_enabled && idle_flag && !model_stable_flag))
    else $error("enable write did not start enabling");
  run_in_a: assert property (
    $rose(trace_enabled) |-> ##[1:EN_MAX] st_run)
    else $error("enabling did not reach running");
  dis_go_a: assert property (ctl_wr && !pwdata[0] && st_run |->
    ##[1:2] (!trace_enabled && !idle_flag && !model_stable_flag))
    else $error("disable write did not reach unstable");
  stb_in_a: assert property (
    $fell(trace_enabled) |-> ##[1:DR_MAX] st_stb)
    else $error("unstable did not reach stable");
  stb_hold_a: assert property (
    st_stb && !(trace_drained && ext_quiescent) |=> !idle_flag)
    else $error("left stable before drained");
  en_flag_a: assert property (trace_enabled |-> !model_stable_flag)
    else $error("stable flag set while enabled");
  idle_flag_a: assert property (idle_flag && !trace_enabled |->
    model_stable_flag)
    else $error("idle without stable flag");
  stb_lock_a: assert property (st_stb |=> !trace_enabled)
    else $error("enabled straight from stable");
  dir_defer_a: assert property (
    dir_en && st_idle && !ctx_sync && !ctl_wr |=> !trace_enabled)
    else $error("direct enable acted before sync");
endmodule
bind tps_ctrl tps_chk #(.ENABLE_CYC(ENABLE_CYC), .DRAIN_CYC(DRAIN_CYC)) u_chk (
  .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .sys_wr(sys_wr), .sys_addr(sys_addr),
  .sys_wdata(sys_wdata), .ctx_sync(ctx_sync), .trace_drained(trace_drained),
  .ext_quiescent(ext_quiescent), .trace_enabled(trace_enabled),
  .idle_flag(idle_flag), .model_stable_flag(model_stable_flag));

/* File: sim/tps_core_mdl.sv */
// far-side model: drain and quiet levels of the traced core
`timescale 1ns/1ps
module tps_core_mdl #(
  parameter int DLY = 3
) (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic trace_enabled,
  input  wire logic hold,
  output logic      trace_drained,
  output logic      ext_quiescent
);
  int cnt;
  // trace keeps flowing a while after disable; hold stalls the drain
  always_ff @(posedge mclk)
  begin
    if (srst || trace_enabled)
      cnt <= 0;
    else if (cnt < DLY)
      cnt <= cnt + 1;
  end
  assign trace_drained = (cnt == DLY) && !hold;
  assign ext_quiescent = !trace_enabled && !hold;
endmodule

/* File: sim/tb.sv */
// self-checking bench of the programming-state controller
`timescale 1ns/1ps
module tb;
  logic        mclk = 1'h0;
  logic        srst = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic        sys_wr = 1'h0;
  logic        sys_rd = 1'h0;
  logic        ctx_sync = 1'h0;
  logic        ind_we = 1'h0;
  logic        hold = 1'h0;
  logic        last_err;
  logic [11:0] paddr = 12'h0;
  logic [11:0] sys_addr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] sys_wdata = 32'h0;
  logic [15:0] ind_cnt = 16'h0;
  logic [7:0]  ind_ss = 8'h0;
  logic [7:0]  auth_pins = 8'h3C;
  logic [31:0] prdata;
  logic [31:0] sys_rdata;
  logic        pready;
  logic        pslverr;
  logic        sys_rvalid;
  logic        trace_enabled;
  logic        idle_flag;
  logic        model_stable_flag;
  logic        trace_drained;
  logic        ext_quiescent;
  int          miscompares = 0;
  int          n_tests = 0;

  tps_ctrl #(.ENABLE_CYC(6), .DRAIN_CYC(6)) u_dut (
    .mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sys_wr(sys_wr), .sys_rd(sys_rd),
    .sys_addr(sys_addr), .sys_wdata(sys_wdata), .sys_rdata(sys_rdata),
    .sys_rvalid(sys_rvalid), .ctx_sync(ctx_sync), .ind_cnt_we(ind_we),
    .ind_cnt_val(ind_cnt), .ind_seq_we(ind_we), .ind_seq_val(2'h2),
    .ind_ss_set(ind_ss), .ind_rsr_we(ind_we), .ind_rsr_val(32'hA5),
    .trace_drained(trace_drained), .ext_quiescent(ext_quiescent),
    .auth_pins(auth_pins), .trace_enabled(trace_enabled),
    .idle_flag(idle_flag), .model_stable_flag(model_stable_flag));

  tps_core_mdl #(.DLY(3)) u_core (
    .mclk(mclk), .srst(srst), .trace_enabled(trace_enabled), .hold(hold),
    .trace_drained(trace_drained), .ext_quiescent(ext_quiescent));

  always #2 mclk = ~mclk;

  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // w=1 writes d, w=0 reads and compares with d
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1)
      @(posedge mclk);
    last_err = pslverr;
    if (!w)
      chk(prdata, d);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask

  task automatic sysx(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    sys_wr <= w;
    sys_rd <= !w;
    sys_addr <= a;
    sys_wdata <= d;
    @(posedge mclk);
    sys_wr <= 1'h0;
    sys_rd <= 1'h0;
    @(posedge mclk);
    if (!w)
      chk({31'h0, sys_rvalid}, 32'h1);
    if (!w)
      chk(sys_rdata, d);
  endtask

  task automatic sync();
    ctx_sync <= 1'h1;
    @(posedge mclk);
    ctx_sync <= 1'h0;
    @(posedge mclk);
  endtask

  task automatic ind(input logic [15:0] c);
    ind_we <= 1'h1;
    ind_cnt <= c;
    ind_ss <= 8'h08;
    @(posedge mclk);
    ind_we <= 1'h0;
    ind_ss <= 8'h00;
    @(posedge mclk);
  endtask

  // f is {enabled, idle, stable}
  task automatic wait_st(input logic [2:0] f);
    int i;
    i = 0;
    while ({trace_enabled, idle_flag, model_stable_flag} !== f && i < 99)
    begin
      @(posedge mclk);
      i++;
    end
    chk({29'h0, trace_enabled, idle_flag, model_stable_flag}, {29'h0, f});
  endtask

  initial
  begin
    repeat (3000) @(posedge mclk);
    miscompares++;
    $display("unexpected at %0t: run hung", $time);
    complete_run();
  end

  initial
  begin
    repeat (2) @(posedge mclk);
    srst <= 1'h0;
    @(posedge mclk);
    wait_st(3'h3);
    apb(0, tps_pkg::OFS_STATE, 32'h3);
    apb(0, tps_pkg::OFS_AUTH, 32'h3C);
    apb(1, tps_pkg::OFS_CNT, 32'h1234);
    apb(0, tps_pkg::OFS_CNT, 32'h1234);
    sync();
    sysx(0, tps_pkg::OFS_CNT, 32'h1234);
    apb(1, tps_pkg::OFS_CLAIM_SET, 32'h0F);
    apb(1, tps_pkg::OFS_CLAIM_CLR, 32'h05);
    apb(0, tps_pkg::OFS_CLAIM_SET, 32'h0A);
    apb(0, 12'h800, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    $display("test idle access done");
    apb(1, tps_pkg::OFS_PRG_CTL, 32'h1);
    wait_st(3'h6);
    wait_st(3'h4);
    sync();
    apb(0, tps_pkg::OFS_STATE, 32'h0);
    apb(1, tps_pkg::OFS_CNT, 32'h5555);
    apb(1, tps_pkg::OFS_CLAIM_SET, 32'h30);
    ind(16'h77);
    apb(0, tps_pkg::OFS_CNT, 32'h77);
    sysx(0, tps_pkg::OFS_CNT, 32'h77);
    apb(0, tps_pkg::OFS_SEQ, 32'h2);
    apb(0, tps_pkg::OFS_SS, 32'h08);
    apb(0, tps_pkg::OFS_CLAIM_SET, 32'h3A);
    // pin change while busy stays out of the outer view until Stable
    auth_pins <= 8'h5A;
    apb(0, tps_pkg::OFS_AUTH, 32'h3C);
    hold <= 1'h1;
    apb(1, tps_pkg::OFS_PRG_CTL, 32'h0);
    wait_st(3'h0);
    apb(1, tps_pkg::OFS_PRG_CTL, 32'h1);
    wait_st(3'h1);
    ind(16'h99);
    apb(0, tps_pkg::OFS_CNT, 32'h77);
    apb(0, tps_pkg::OFS_RSR, 32'hA5);
    sync();
    sysx(0, tps_pkg::OFS_RSR, 32'hA5);
    apb(0, tps_pkg::OFS_AUTH, 32'h5A);
    sysx(0, tps_pkg::OFS_AUTH, 32'h5A);
    repeat (8) @(posedge mclk);
    wait_st(3'h1);
    hold <= 1'h0;
    wait_st(3'h3);
    apb(0, tps_pkg::OFS_PRG_CTL, 32'h0);
    $display("test trace session done");
    sysx(1, tps_pkg::OFS_PRG_CTL, 32'h1);
    repeat (2) @(posedge mclk);
    wait_st(3'h3);
    sync();
    wait_st(3'h6);
    wait_st(3'h4);
    sysx(1, tps_pkg::OFS_PRG_CTL, 32'h0);
    sync();
    wait_st(3'h3);
    $display("test direct enable done");
    // reset while running must drop back to a clean Idle
    apb(1, tps_pkg::OFS_PRG_CTL, 32'h1);
    wait_st(3'h4);
    srst <= 1'h1;
    repeat (2) @(posedge mclk);
    srst <= 1'h0;
    @(posedge mclk);
    wait_st(3'h3);
    apb(0, tps_pkg::OFS_PRG_CTL, 32'h0);
    apb(0, tps_pkg::OFS_CLAIM_SET, 32'h0);
    $display("test reset in run done");
    complete_run();
  end
endmodule
